//--- core/lan_ctrl.sv
// Purpose: Copper link auto-negotiation controller with AXI4-Lite register access.
// Assumes: Line pulse, detect and link inputs come from analog front end, asynchronous.
// Notes: Pulse-level timing abstracted to events; page exchange is a word per burst.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`include "lan_map.svh"
`timescale 1ns/1ps
`default_nettype none
module lan_ctrl #(
    parameter int unsigned CLK_MHZ = `LAN_CLK_MHZ,
    parameter int unsigned BURST_CYC = `LAN_T_BURST_MS * 1000 * CLK_MHZ,
    parameter int unsigned BRMIN_CYC = (`LAN_T_BRMIN_US * CLK_MHZ),
    parameter int unsigned BRMAX_CYC = `LAN_T_BRMAX_MS * 1000 * CLK_MHZ,
    parameter int unsigned NLPMIN_CYC = `LAN_T_NLPMIN_US * CLK_MHZ,
    parameter int unsigned NLPMAX_CYC = `LAN_T_NLPMAX_MS * 1000 * CLK_MHZ,
    parameter int unsigned LOSS_CYC = `LAN_T_LOSS_MS * 1000 * CLK_MHZ,
    parameter int unsigned BREAK_CYC = `LAN_T_BREAK_MS * 1000 * CLK_MHZ,
    parameter int unsigned PDET_CYC = `LAN_T_PDET_MS * 1000 * CLK_MHZ,
    parameter int unsigned LEN_CYC = `LAN_T_LEN_MS * 1000 * CLK_MHZ
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic             line_pulse,
    input  wire logic             line_data,
    input  wire logic [15:0]      line_page,
    input  wire logic             line_10_sig,
    input  wire logic             line_100_sig,
    input  wire logic             line_up,
    input  wire logic             ms_resolved,
    input  wire logic             ms_fault,
    output logic                  tx_pulse,
    output logic [2:0]            link_mode,
    output logic                  link_ok,
    output logic                  irq
);
    import lan_pkg::*;

    localparam int unsigned PULSE_CYC  = (`LAN_T_PULSE_NS * CLK_MHZ) / 1000;
    localparam int unsigned FLPMIN_CYC = (`LAN_T_FLPMIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned FLPMAX_CYC = (`LAN_T_FLPMAX_NS * CLK_MHZ) / 1000;
    localparam int unsigned DMIN_CYC   = (`LAN_T_DMIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned DMAX_CYC   = (`LAN_T_DMAX_NS * CLK_MHZ) / 1000;

    typedef enum logic [2:0] {ST_BREAK, ST_ABILITY, ST_ACK, ST_MS, ST_WAIT, ST_PDET, ST_UP, ST_FORCE} lan_st_e;

    // Synchronisers: stage one feeds stage two only
    logic [6:0] sy1, sy2;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sy1 <= 7'h00;
            sy2 <= 7'h00;
        end else begin
            sy1 <= {line_pulse, line_data, line_10_sig, line_100_sig, line_up, ms_resolved, ms_fault};
            sy2 <= sy1;
        end
    end
    logic p_s, d_s, s10, s100, up_s, msr_s, msf_s;
    assign {p_s, d_s, s10, s100, up_s, msr_s, msf_s} = sy2;
    logic [15:0] page_q, page_r;
    logic        p_d;

    function automatic lan_mode_e best(input logic [15:0] a, input logic [15:0] g);
        // Highest common ability by priority
        if (g[1])      best = LAN_M_1000F;
        else if (g[0]) best = LAN_M_1000H;
        else if (a[8]) best = LAN_M_100F;
        else if (a[7]) best = LAN_M_100H;
        else if (a[6]) best = LAN_M_10F;
        else if (a[5]) best = LAN_M_10H;
        else           best = LAN_M_NONE;
    endfunction : best

    // Registers and state
    logic [15:0] ctrl, adv, gadv, lpa, lpx, glpa, lat_adv, lat_gadv;
    logic [3:0]  ist, ien;
    lan_st_e     st, next_st;
    logic [31:0] tmr, next_tmr, gap, next_gap, txc, next_txc;
    logic [3:0]  burst_ok_cnt, next_burst_ok_cnt;
    lan_mode_e   mode, next_mode;
    logic        sped_chg;
    logic        tx_pulse_r, next_tx_pulse;

    // Bus slave
    logic        aw_h, w_h, next_aw_h, next_w_h;
    logic [7:0]  aw_a, next_aw_a;
    logic [31:0] w_d, next_w_d;
    logic        bv, next_bv, rv, next_rv;
    logic [31:0] rd, next_rd;
    logic [1:0]  br, next_br, rr, next_rr;
    logic        wr_go;
    logic [4:0]  wi;
    logic        map_ok_w, map_ok_r;
    logic [15:0] rword;

    function automatic logic mapped(input logic [4:0] i);
        mapped = i inside {`LAN_REG_CTRL, `LAN_REG_STAT, `LAN_REG_ADV, `LAN_REG_LPA, `LAN_REG_LPX,
                           `LAN_REG_GADV, `LAN_REG_GLPA, `LAN_REG_IRQ, `LAN_REG_IEN, `LAN_REG_ICLR, `LAN_REG_MODE};
    endfunction : mapped

    assign wr_go = aw_h && w_h && !bv;
    assign wi = aw_a[6:2];
    assign map_ok_w = mapped(wi) && (aw_a[7] == 1'b0);
    assign map_ok_r = mapped(s_axi_araddr[6:2]) && (s_axi_araddr[7] == 1'b0);

    always_comb begin
        next_aw_h = aw_h;
        next_w_h = w_h;
        next_aw_a = aw_a;
        next_w_d = w_d;
        next_bv = bv;
        next_br = br;
        next_rv = rv;
        next_rd = rd;
        next_rr = rr;
        rword = 16'h0000;
        if (s_axi_awvalid && !aw_h) begin
            next_aw_h = 1'b1;
            next_aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_h) begin
            next_w_h = 1'b1;
            next_w_d = s_axi_wdata;
        end
        if (wr_go) begin
            next_bv = 1'b1;
            next_br = map_ok_w ? LAN_RS_OKAY : LAN_RS_SLVERR;
            next_aw_h = 1'b0;
            next_w_h = 1'b0;
        end
        if (bv && s_axi_bready) next_bv = 1'b0;
        unique case (s_axi_araddr[6:2])
            `LAN_REG_CTRL: rword = ctrl;
            `LAN_REG_STAT: rword = {13'h0000, link_ok, 2'b00};
            `LAN_REG_ADV:  rword = adv;
            `LAN_REG_LPA:  rword = lpa;
            `LAN_REG_LPX:  rword = lpx;
            `LAN_REG_GADV: rword = gadv;
            `LAN_REG_GLPA: rword = glpa;
            `LAN_REG_IRQ:  rword = {12'h000, ist};
            `LAN_REG_IEN:  rword = {12'h000, ien};
            `LAN_REG_MODE: rword = {9'h000, 4'(st), link_mode};
            default:       rword = 16'h0000;
        endcase
        if (s_axi_arvalid && !rv) begin
            next_rv = 1'b1;
            next_rd = map_ok_r ? {16'h0000, rword} : 32'h0000_0000;
            next_rr = map_ok_r ? LAN_RS_OKAY : LAN_RS_SLVERR;
        end else if (rv && s_axi_rready) begin
            next_rv = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_h <= 1'b0;
            w_h <= 1'b0;
            aw_a <= 8'h00;
            w_d <= 32'h0000_0000;
            bv <= 1'b0;
            br <= 2'b00;
            rv <= 1'b0;
            rd <= 32'h0000_0000;
            rr <= 2'b00;
        end else begin
            aw_h <= next_aw_h;
            w_h <= next_w_h;
            aw_a <= next_aw_a;
            w_d <= next_w_d;
            bv <= next_bv;
            br <= next_br;
            rv <= next_rv;
            rd <= next_rd;
            rr <= next_rr;
        end
    end

    // Control registers; byte strobes ignored, whole word written
    logic [15:0] next_ctrl, next_adv, next_gadv;
    logic [3:0]  next_ien, next_ist, ev;
    logic        restart_taken;
    always_comb begin
        next_ctrl = ctrl;
        next_adv = adv;
        next_gadv = gadv;
        next_ien = ien;
        if (wr_go && map_ok_w) begin
            unique case (wi)
                `LAN_REG_CTRL: next_ctrl = w_d[15:0];
                `LAN_REG_ADV:  next_adv = w_d[15:0];
                `LAN_REG_GADV: next_gadv = w_d[15:0];
                `LAN_REG_IEN:  next_ien = w_d[3:0];
                default:       next_ien = next_ien;
            endcase
        end
        if (restart_taken) next_ctrl[`LAN_CTRL_RESTART] = 1'b0;
        // Events: done, link up, link down, parallel detect; set beats clear
        next_ist = ist;
        if (wr_go && map_ok_w && wi == `LAN_REG_ICLR) next_ist = ist & ~w_d[3:0];
        next_ist = next_ist | ev;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= `LAN_CTRL_RST | (16'h0001 << `LAN_CTRL_ANEN);
            adv <= `LAN_ADV_RST;
            gadv <= `LAN_GADV_RST;
            ien <= 4'h0;
            ist <= 4'h0;
        end else begin
            ctrl <= next_ctrl;
            adv <= next_adv;
            gadv <= next_gadv;
            ien <= next_ien;
            ist <= next_ist;
        end
    end

    // Negotiation machine
    logic [15:0] next_lpa, next_lpx, next_glpa, next_lat_adv, next_lat_gadv;
    logic        next_link, next_irq;
    logic [1:0]  fspd;
    lan_mode_e   fmode;
    assign fspd = {ctrl[`LAN_CTRL_SPD1], ctrl[`LAN_CTRL_SPD0]};
    // Forced gigabit falls to 100 since gigabit needs negotiation
    assign fmode = (fspd == 2'b00) ? (ctrl[`LAN_CTRL_DUP] ? LAN_M_10F : LAN_M_10H)
                                   : (ctrl[`LAN_CTRL_DUP] ? LAN_M_100F : LAN_M_100H);
    always_comb begin
        next_st = st;
        next_tmr = (tmr == 32'hFFFF_FFFF) ? tmr : tmr + 32'd1;
        next_gap = (gap == 32'hFFFF_FFFF) ? gap : gap + 32'd1;
        next_txc = txc + 32'd1;
        next_tx_pulse = 1'b0;
        next_mode = mode;
        next_burst_ok_cnt = burst_ok_cnt;
        next_lpa = lpa;
        next_lpx = lpx;
        next_glpa = glpa;
        next_lat_adv = lat_adv;
        next_lat_gadv = lat_gadv;
        restart_taken = 1'b0;
        ev = 4'h0;
        sped_chg = 1'b0;
        // Bursts each 16 ms, pulses 68 us apart inside
        if (st == ST_ABILITY || st == ST_ACK) begin
            if (txc >= BURST_CYC) next_txc = 32'd0;
            if (txc < 32'(PULSE_CYC) * 32'd17 && (txc % PULSE_CYC) == 32'd0) next_tx_pulse = 1'b1;
        end else next_txc = 32'd0;
        if (p_s && !p_d) begin
            next_gap = 32'd0;
            // Burst spacing window pulse gap and data windows
            if (gap >= FLPMIN_CYC && gap <= FLPMAX_CYC) begin
                if (d_s && gap >= DMIN_CYC && gap <= DMAX_CYC) next_lpx = page_q;
            end else if (gap >= BRMIN_CYC && gap <= BRMAX_CYC) begin
                next_burst_ok_cnt = (burst_ok_cnt == 4'hF) ? burst_ok_cnt : burst_ok_cnt + 4'd1;
            end else if (gap >= NLPMIN_CYC && gap <= NLPMAX_CYC) begin
                next_burst_ok_cnt = burst_ok_cnt; // Normal link pulse spacing
            end else next_burst_ok_cnt = 4'd0;
        end
        // Settings changes wait for restart or link down/up; a forced speed change acts at once only while link is up
        if (ctrl[`LAN_CTRL_RESTART]) begin
            restart_taken = 1'b1;
            next_st = ST_BREAK;
            next_tmr = 32'd0;
        end else if (link_ok && ctrl[`LAN_CTRL_ANEN] == 1'b0 && fmode != mode) begin
            sped_chg = 1'b1; // Speed change drops the link
            next_st = ST_BREAK;
            next_tmr = 32'd0;
        end else begin
            unique case (st)
                ST_BREAK: if (tmr >= BREAK_CYC) begin
                    next_tmr = 32'd0;
                    next_burst_ok_cnt = 4'd0;
                    next_lat_adv = adv;
                    next_lat_gadv = gadv;
                    next_st = ctrl[`LAN_CTRL_ANEN] ? ST_ABILITY : ST_FORCE;
                end
                ST_ABILITY: begin
                    if (burst_ok_cnt >= 4'd3) begin
                        next_st = ST_ACK;
                        next_lpa = page_q;
                        next_tmr = 32'd0;
                    end else if (s10 || s100) begin
                        next_st = ST_PDET;
                        next_tmr = 32'd0;
                    end
                end
                ST_ACK: begin
                    // Common mode resolved from both pages
                    // Gig page taken live; glpa would still hold the last partner's
                    next_mode = best(lat_adv & lpa, lat_gadv & page_q);
                    next_tmr = 32'd0;
                    ev[0] = 1'b1;
                    next_st = (next_mode == LAN_M_1000F || next_mode == LAN_M_1000H) ? ST_MS : ST_WAIT;
                end
                ST_MS: begin
                    // Master/slave first, else break and renegotiate
                    if (msf_s) begin
                        next_st = ST_BREAK;
                        next_tmr = 32'd0;
                    end else if (msr_s) begin
                        next_st = ST_WAIT;
                        next_tmr = 32'd0;
                    end else if (tmr >= LEN_CYC) begin
                        next_st = ST_BREAK;
                        next_tmr = 32'd0;
                    end
                end
                ST_PDET: begin
                    if (!(s10 ^ s100)) begin
                        next_st = ST_ABILITY;
                        next_tmr = 32'd0;
                    end else if (tmr >= PDET_CYC) begin
                        next_mode = s100 ? LAN_M_100H : LAN_M_10H;
                        next_lpa = 16'h0000;
                        ev[3] = 1'b1;
                        next_st = ST_WAIT;
                        next_tmr = 32'd0;
                    end
                end
                ST_FORCE: begin
                    next_mode = fmode;
                    next_st = ST_WAIT;
                    next_tmr = 32'd0;
                end
                ST_WAIT: begin
                    if (up_s) begin
                        next_st = ST_UP;
                        next_gap = 32'd0;
                        ev[1] = 1'b1;
                    end else if (tmr >= LEN_CYC) begin
                        next_st = ST_BREAK;
                        next_tmr = 32'd0;
                    end
                end
                ST_UP: begin
                    if (up_s) next_tmr = 32'd0;
                    else if (tmr >= LOSS_CYC) begin
                        next_st = ST_BREAK;
                        next_tmr = 32'd0;
                        ev[2] = 1'b1;
                    end
                end
            endcase
        end
        next_link = (next_st == ST_UP);
        if (st == ST_ACK) next_glpa = page_q;
        next_irq = |(next_ist & next_ien);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= ST_BREAK;
            tmr <= 32'd0;
            gap <= 32'hFFFF_FFFF;
            txc <= 32'd0;
            mode <= LAN_M_NONE;
            burst_ok_cnt <= 4'd0;
            lpa <= 16'h0000;
            lpx <= 16'h0000;
            glpa <= 16'h0000;
            lat_adv <= `LAN_ADV_RST;
            lat_gadv <= `LAN_GADV_RST;
            tx_pulse_r <= 1'b0;
            link_ok <= 1'b0;
            irq <= 1'b0;
            p_d <= 1'b0;
            page_r <= 16'h0000;
            page_q <= 16'h0000;
        end else begin
            st <= next_st;
            tmr <= next_tmr;
            gap <= next_gap;
            txc <= next_txc;
            mode <= next_mode;
            burst_ok_cnt <= next_burst_ok_cnt;
            lpa <= next_lpa;
            lpx <= next_lpx;
            glpa <= next_glpa;
            lat_adv <= next_lat_adv;
            lat_gadv <= next_lat_gadv;
            tx_pulse_r <= next_tx_pulse;
            link_ok <= next_link;
            irq <= next_irq;
            p_d <= p_s;
            page_r <= line_page;
            page_q <= page_r; // Page word only read after burst settles
        end
    end

    assign tx_pulse = tx_pulse_r;
    assign link_mode = mode;
    assign s_axi_awready = !aw_h;
    assign s_axi_wready = !w_h;
    assign s_axi_bvalid = bv;
    assign s_axi_bresp = br;
    assign s_axi_arready = !rv;
    assign s_axi_rvalid = rv;
    assign s_axi_rdata = rd;
    assign s_axi_rresp = rr;

    a_restart_clear: assert property (@(posedge clk) disable iff (!reset_n)
        ctrl[`LAN_CTRL_RESTART] |=> !ctrl[`LAN_CTRL_RESTART] || $past(wr_go)) else $error("restart bit stuck");
    a_restart_break: assert property (@(posedge clk) disable iff (!reset_n)
        ctrl[`LAN_CTRL_RESTART] |=> st == ST_BREAK) else $error("restart not taken");
    a_giga_neg: assert property (@(posedge clk) disable iff (!reset_n)
        (st == ST_FORCE || st == ST_PDET) |=> !(mode inside {LAN_M_1000F, LAN_M_1000H}) || st != ST_WAIT)
        else $error("gigabit without negotiation");
    a_ms_first: assert property (@(posedge clk) disable iff (!reset_n)
        (st == ST_ACK && next_st == ST_WAIT) |-> !(next_mode inside {LAN_M_1000F, LAN_M_1000H}))
        else $error("gigabit skipped master slave");
    a_link_state: assert property (@(posedge clk) disable iff (!reset_n)
        link_ok == $past(next_st == ST_UP)) else $error("link flag mismatch");
    a_break_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (st == ST_BREAK && next_st != ST_BREAK) |-> tmr >= BREAK_CYC || ctrl[`LAN_CTRL_RESTART])
        else $error("break too short");
    a_pdet_wait: assert property (@(posedge clk) disable iff (!reset_n)
        (st == ST_PDET && next_st == ST_WAIT) |-> tmr >= PDET_CYC) else $error("parallel detect early");
    a_irq_level: assert property (@(posedge clk) disable iff (!reset_n)
        ##1 irq == |($past(next_ist) & $past(next_ien))) else $error("irq level wrong");
    a_speed_drop: assert property (@(posedge clk) disable iff (!reset_n)
        sped_chg |=> st == ST_BREAK && !link_ok) else $error("speed change kept link");
    a_tx_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        tx_pulse |-> $past(st == ST_ABILITY || st == ST_ACK)) else $error("pulse outside negotiation");
    c_up: cover property (@(posedge clk) disable iff (!reset_n) st == ST_WAIT ##1 st == ST_UP);
    c_pdet: cover property (@(posedge clk) disable iff (!reset_n) st == ST_PDET ##1 st == ST_WAIT);
    c_ms: cover property (@(posedge clk) disable iff (!reset_n) st == ST_MS ##1 st == ST_WAIT);
endmodule : lan_ctrl
`default_nettype wire

//--- include/lan_map.svh
// Purpose: Register offsets, fields, reset values and timer durations for the negotiation controller.
// Assumes: 25 MHz clock, AXI4-Lite byte addressing, word index times four.
// Notes: Times are kept in their own unit; cycle counts derive from them.
// Contract
// - Rank modes: 1000 full, 1000 half, 100 full, 100 half, 10 full, 10 half.
// - Advertise own abilities and select highest mode common to both partners; code transmits only timing pulses, no ability page.
// - Non-negotiating 10/100 partner: pick mode from line signal, parallel detection.
// - Gigabit link only ever comes up through completed negotiation.
// - Gigabit negotiation resolves master/slave before establishing the link.
// - Negotiation on after reset; then control bit 12 enables or disables it.
// - Negotiation off: speed from control bits 6 and 13, duplex bit 8.
// - Speed change while running drops link and reruns negotiation or detection; code acts only with negotiation off and reapplies forced mode.
// - Other setting changes apply only after restart bit 9 or link down/up.
// - On completion update status bit 2 and partner registers 5, 6, 0xA.
// - Transmit bursts every 16 ms, pulses within burst every 68 us.
// - Accept in-burst pulse gap only between 17.2 us and 185 us.
// - Bursts valid only when spaced 6.8 ms to 112 ms apart.
// - Data pulse decoded 35.4 us to 95 us after preceding clock pulse.
// - Normal link pulses recognised only when spaced 4.5 ms to 30 ms.
// - Link loss after 52 ms idle; break link held 1480 ms on renegotiation.
// - Parallel detection mode accepted only after 830 ms stable signal.
// - Resolved mode gets 1000 ms to come up, else negotiation restarts.
`ifndef LAN_MAP_SVH
`define LAN_MAP_SVH

`define LAN_CLK_MHZ        25
`define LAN_REG_CTRL       5'h00
`define LAN_REG_STAT       5'h01
`define LAN_REG_ADV        5'h04
`define LAN_REG_LPA        5'h05
`define LAN_REG_LPX        5'h06
`define LAN_REG_GADV       5'h09
`define LAN_REG_GLPA       5'h0A
`define LAN_REG_IRQ        5'h1B
`define LAN_REG_IEN        5'h1C
`define LAN_REG_ICLR       5'h1D
`define LAN_REG_MODE       5'h1F
`define LAN_CTRL_RST       16'h0000
`define LAN_CTRL_SPD0      6
`define LAN_CTRL_DUP       8
`define LAN_CTRL_RESTART   9
`define LAN_CTRL_ANEN      12
`define LAN_CTRL_SPD1      13
`define LAN_STAT_LINK      2
`define LAN_ADV_RST        16'h01E1
`define LAN_GADV_RST       16'h0300

`define LAN_T_BURST_MS     16
`define LAN_T_PULSE_NS     68000
`define LAN_T_FLPMIN_NS    17200
`define LAN_T_FLPMAX_NS    185000
`define LAN_T_BRMIN_US     6800
`define LAN_T_BRMAX_MS     112
`define LAN_T_DMIN_NS      35400
`define LAN_T_DMAX_NS      95000
`define LAN_T_NLPMIN_US    4500
`define LAN_T_NLPMAX_MS    30
`define LAN_T_LOSS_MS      52
`define LAN_T_BREAK_MS     1480
`define LAN_T_PDET_MS      830
`define LAN_T_LEN_MS       1000

`endif

//--- include/lan_pkg.sv
// Purpose: Types of the negotiation controller.
// Assumes: Nothing beyond the map header.
// Notes: Mode order follows priority, highest first.
package lan_pkg;
    typedef enum logic [2:0] {
        LAN_M_1000F, LAN_M_1000H, LAN_M_100F, LAN_M_100H, LAN_M_10F, LAN_M_10H, LAN_M_NONE
    } lan_mode_e;
    typedef enum logic [1:0] {LAN_RS_OKAY = 2'b00, LAN_RS_SLVERR = 2'b10} lan_resp_e;
endpackage : lan_pkg

//--- dv/lan_peer.sv
// Purpose: Remote partner on the twisted pair.
// Assumes: One pulse per burst, page steady while negotiating.
// Notes: Page inverted when not negotiating, never left stale.
`timescale 1ns/1ps
`default_nettype none
module lan_peer (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        neg,
    input  wire logic        fix10,
    input  wire logic        fix100,
    input  wire logic [15:0] page,
    input  wire logic [2:0]  mode,
    output logic             pulse,
    output logic             data,
    output logic [15:0]      page_o,
    output logic             up
);
    logic [8:0] gap;
    assign data = gap[0];
    assign page_o = neg ? page : ~page;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gap <= '0;
            pulse <= 1'b0;
            up <= 1'b0;
        end else begin
            gap <= (gap == 9'd299) ? 9'd0 : gap + 9'd1;
            pulse <= (neg | fix10) & (gap < 9'd2);
            // Link holds while negotiating with any resolved mode, else only while our forced speed matches the partner's
            up <= (neg & (mode != 3'd6)) | (fix10 & (mode[2:1] == 2'b10)) | (fix100 & (mode[2:1] == 2'b01));
        end
    end
endmodule : lan_peer
`default_nettype wire

//--- dv/lan_ctrl_test.sv
// Purpose: Self-checking bench of the negotiation controller.
// Assumes: Short timer counts so a run stays brief.
// Notes: Read data and link modes checked from queues.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); end end
module lan_ctrl_test;
    import lan_pkg::*;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} lan_exp_s;
    logic        clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, neg;
    logic        line_pulse, line_data, line_10_sig, line_100_sig, line_up, ms_resolved, ms_fault;
    logic        tx_pulse, link_ok, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] line_page, adv, p;
    logic [2:0]  link_mode;
    lan_exp_s    rq[$], e;
    lan_mode_e   mq[$], m;
    int          num_errors, checks, cyc, txn;
    lan_ctrl #(.BURST_CYC(200), .BRMIN_CYC(100), .BRMAX_CYC(800), .NLPMIN_CYC(50), .NLPMAX_CYC(400),
        .LOSS_CYC(600), .BREAK_CYC(100), .PDET_CYC(150), .LEN_CYC(500)) dut (.*);
    lan_peer peer (.clk(clk), .reset_n(reset_n), .neg(neg), .fix10(line_10_sig), .fix100(line_100_sig),
        .page(adv), .mode(link_mode), .pulse(line_pulse), .data(line_data), .page_o(line_page), .up(line_up));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Ceiling well above the six link bring-ups
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            num_errors++;
            results();
        end
    end
    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
            e = rq.pop_front();
            `CHK("rdata", s_axi_rdata & e.m, e.d)
            `CHK("rresp", s_axi_rresp, e.r)
        end
        if (tx_pulse === 1'b1) txn++;
        if ($rose(link_ok) && mq.size() > 0) begin
            m = mq.pop_front();
            `CHK("link_mode", link_mode, m)
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'($urandom);
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) s_axi_bready <= 1'b0;
        end while (!s_axi_bvalid);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] k, input logic [1:0] r);
        @(posedge clk);
        rq.push_back('{d, k, r});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : rd
    // Link must drop before the new mode counts
    task automatic relink;
        while (link_ok === 1'b1) @(posedge clk);
        while (link_ok !== 1'b1) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask : relink
    task automatic results;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    initial begin
        {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {line_10_sig, line_100_sig, ms_fault, neg, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        ms_resolved = 1'b1;
        s_axi_wstrb = 4'hF;
        adv = 16'h01E1;
        void'($urandom(32'he159b123));
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        rd(8'h00, 32'h1000, 32'h1000, LAN_RS_OKAY);
        rd(8'h08, 32'h0, 32'hFFFF_FFFF, LAN_RS_SLVERR);
        wr(8'h70, 32'h2);
        mq.push_back(LAN_M_100F);
        neg <= 1'b1;
        relink();
        `CHK("irq", irq, 1'b1)
        wr(8'h74, 32'h2);
        rd(8'h6C, 32'h0, 32'h2, LAN_RS_OKAY);
        `CHK("irq", irq, 1'b0)
        rd(8'h04, 32'h4, 32'h4, LAN_RS_OKAY);
        repeat (2) begin
            p = ($urandom % 2) ? 16'h01E1 : 16'h00A1;
            adv <= p;
            mq.push_back(p[8] ? LAN_M_100F : LAN_M_100H);
            wr(8'h00, 32'h1200);
            rd(8'h00, 32'h1000, 32'h1200, LAN_RS_OKAY);
            relink();
            rd(8'h14, {16'h0, p}, 32'hFFFF, LAN_RS_OKAY);
        end
        wr(8'h24, 32'h3);
        adv <= 16'h01E3;
        {ms_fault, ms_resolved} <= 2'b10;
        mq.push_back(LAN_M_1000F);
        wr(8'h00, 32'h1200);
        repeat (3000) @(posedge clk);
        `CHK("link_ok", link_ok, 1'b0)
        {ms_fault, ms_resolved} <= 2'b01;
        relink();
        mq.push_back(LAN_M_10H);
        neg <= 1'b0;
        line_10_sig <= 1'b1;
        relink();
        mq.push_back(LAN_M_100F);
        line_10_sig <= 1'b0;
        line_100_sig <= 1'b1;
        wr(8'h00, 32'h0140);
        relink();
        `CHK("tx_pulse", txn > 0, 1'b1)
        results();
    end
endmodule : lan_ctrl_test
`undef CHK
`default_nettype wire
